// ==== include/fxrpcs_pkg.sv ====
// Package of constants and types for the 100 Mb/s receive coding back end
package fxrpcs_pkg;
  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_BASIC_LINK_STATUS  = 8'h01;
  localparam logic [7:0] IDX_DISCONNECT_COUNT   = 8'h13;
  localparam logic [7:0] IDX_FALSE_CARRIER      = 8'h14;
  localparam logic [7:0] IDX_CODING_CFG_STATUS  = 8'h16;
  localparam logic [7:0] IDX_LOOPBACK_BYPASS    = 8'h17;
  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int          BIT_LINK_VALID   = 2;
  localparam int          BIT_UNSTABLE     = 4;
  localparam int          BIT_CIM_DISABLE  = 5;
  localparam int          BIT_RX_BYPASS    = 11;
  localparam int          BIT_DESC_BYPASS  = 12;
  localparam logic [15:0] RST_COUNT        = 16'h0000;
  localparam logic [15:0] RST_LOOPBACK     = 16'h0000;
  // ****************************************************************
  // Code-groups and nibbles
  // ****************************************************************
  localparam logic [9:0]  CG_JK            = 10'h311;
  localparam logic [4:0]  CG_IDLE          = 5'h1f;
  localparam logic [4:0]  CG_T             = 5'h0d;
  localparam logic [4:0]  CG_R             = 5'h07;
  localparam logic [3:0]  NIB_PREAMBLE     = 4'h5;
  localparam logic [3:0]  NIB_BAD_START    = 4'he;
  localparam logic [3:0]  END_IDLES        = 4'h2;
  localparam logic [3:0]  SYNC_IDLES       = 4'hc;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLK_MHZ          = 100;
  localparam int          SD_TIME_US       = 500;
  localparam int          SD_CYCLES        = SD_TIME_US * CLK_MHZ;
  localparam logic [3:0]  CIM_BAD_LIMIT    = 4'h2;
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic       er;
    logic       dv;
    logic       crs;
    logic [3:0] d;
  } fxr_mii_rx_t;
  typedef enum logic [1:0] {S_IDLE, S_PRE_K, S_DATA, S_BAD} fxr_state_t;
endpackage

// ==== rtl/fxrpcs_rx.sv ====
// Receive code-group aligner, decoder, link and carrier monitors with APB registers
//
// Function
// - Find 11000 10001 start pattern, then lock symbol boundary there.
// - With descrambler bypassed, take words straight from the NRZ decoder.
// - Accept start delimiter only after idle code-groups.
// - Emit two 0101 nibbles for J/K, then decode 5B via table.
// - Stop decoding on T/R or on two idles.
// - Block transmit and receive until the link is valid.
// - Without negotiation, link valid after signal detect held 500 us.
// - With negotiation, also need 12 idles and 100 Mb/s selected.
// - Report link in status bit 2 at 01h, and on link output only while negotiation is disabled.
// - Idles to non-idle without J/K is a bad start delimiter.
// - In bad start state, drive error and data 1110 each symbol.
// - Leave bad start state only after two idles; drop error and carrier.
// - Each bad start delimiter adds one to false carrier counter 14h.
// - Receive bypass bit 11 stops the bad start overrides.
// - Strap sets reset value of monitor disable bit 5; software may change.
// - Unstable link withholds receive data and drops transmit data.
// - Keep monitoring while unstable; resume once stable.
// - Unstable sets sticky bit 4; read clears it only once stable.
// - Disconnect counter 13h adds one on each new unstable verdict.
// - Idle is 11111; descrambler sync after 12 consecutive idles.
`timescale 1ns/100ps
`default_nettype none
module fxrpcs_rx
  import fxrpcs_pkg::*;
#(
  parameter int SD_HOLD_CYCLES = SD_CYCLES
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        symClk,
  input  wire logic [4:0]  descWord,
  input  wire logic [4:0]  nrzWord,
  input  wire logic        signalDetect,
  input  wire logic        repeaterStrap,
  input  wire logic        anEnable,
  input  wire logic        anSel100,
  input  wire logic        txEnIn,
  input  wire logic [3:0]  txdIn,
  output fxr_mii_rx_t      miiRx,
  output logic             rxStrobe,
  output logic             txEnOut,
  output logic [3:0]       txdOut,
  output logic             linkLed
);
  // Hold count must fit the 16-bit detect counter
  if (SD_HOLD_CYCLES < 1 || SD_HOLD_CYCLES > 65535)
  begin : g_bad_hold
    $error("SD_HOLD_CYCLES out of range");
  end

  // ****************************************************************
  // Pin synchronisers and symbol edge
  // ****************************************************************
  logic [2:0]  sclkS_q;
  logic [4:0]  descS1_q, descS2_q, nrzS1_q, nrzS2_q;
  logic [1:0]  sdS_q, strapS_q;
  logic        symEdge;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sclkS_q  <= 3'h0;
      descS1_q <= 5'h00;
      descS2_q <= 5'h00;
      nrzS1_q  <= 5'h00;
      nrzS2_q  <= 5'h00;
      sdS_q    <= 2'h0;
    end
    else if (ce)
    begin
      sclkS_q  <= {sclkS_q[1:0], symClk};
      descS1_q <= descWord;
      descS2_q <= descS1_q;
      nrzS1_q  <= nrzWord;
      nrzS2_q  <= nrzS1_q;
      sdS_q    <= {sdS_q[0], signalDetect};
    end
  end

  // Strap synchroniser runs through reset so its value is ready at release
  always_ff @(posedge clk)
  begin
    if (ce)
      strapS_q <= {strapS_q[0], repeaterStrap};
  end

  // Words are taken at the falling link edge, mid-way between launches
  assign symEdge = ce && sclkS_q[2] && !sclkS_q[1];

  // ****************************************************************
  // Registers held by software
  // ****************************************************************
  logic [15:0] loopback_q;
  logic        cimDis_q, strapLoad_q;

  // ****************************************************************
  // Bit history and pattern search
  // ****************************************************************
  logic [14:0] hist_q;
  logic [4:0]  rawWord, jkHit;
  logic [2:0]  phase_q, hitPhase;
  logic        anyHit;
  logic [4:0]  curSym, prevSym;

  assign rawWord = loopback_q[BIT_DESC_BYPASS] ? nrzS2_q : descS2_q;

  always_ff @(posedge clk)
  begin
    if (rst)
      hist_q <= 15'h0000;
    else if (symEdge)
      hist_q <= {hist_q[9:0], rawWord};
  end

  for (genvar k = 0; k < 5; k++)
  begin : g_search
    assign jkHit[k] = (hist_q[k +: 10] == CG_JK);
  end

  always_comb
  begin
    hitPhase = 3'h0;
    for (int k = 4; k >= 0; k--)
      if (jkHit[k])
        hitPhase = 3'(k);
  end
  assign anyHit  = |jkHit;
  assign curSym  = hist_q[phase_q +: 5];
  // Widened first: phase plus five does not fit three bits
  assign prevSym = hist_q[({1'b0, phase_q} + 4'h5) +: 5];

  function automatic logic [4:0] dec5b(input logic [4:0] s);
    logic [4:0] r;
    r = 5'h10;
    case (s)
      5'h1e: r = 5'h00;
      5'h09: r = 5'h01;
      5'h14: r = 5'h02;
      5'h15: r = 5'h03;
      5'h0a: r = 5'h04;
      5'h0b: r = 5'h05;
      5'h0e: r = 5'h06;
      5'h0f: r = 5'h07;
      5'h12: r = 5'h08;
      5'h13: r = 5'h09;
      5'h16: r = 5'h0a;
      5'h17: r = 5'h0b;
      5'h1a: r = 5'h0c;
      5'h1b: r = 5'h0d;
      5'h1c: r = 5'h0e;
      5'h1d: r = 5'h0f;
      default: r = 5'h10;
    endcase
    return r;
  endfunction

  // ****************************************************************
  // Link validity
  // ****************************************************************
  logic [15:0] sdCnt_q;
  logic [3:0]  syncIdles_q;
  logic        descSync, linkOk_q, linkOk_d;

  assign descSync = (syncIdles_q >= SYNC_IDLES);
  assign linkOk_d = (sdCnt_q == 16'(SD_HOLD_CYCLES))
                    && (!anEnable || (descSync && anSel100));

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sdCnt_q     <= 16'h0000;
      syncIdles_q <= 4'h0;
      linkOk_q    <= 1'b0;
    end
    else if (ce)
    begin
      if (!sdS_q[1])
        sdCnt_q <= 16'h0000;
      else if (sdCnt_q != 16'(SD_HOLD_CYCLES))
        sdCnt_q <= sdCnt_q + 16'h0001;
      // Sync stays until signal detect drops, so packets do not lose it
      if (!sdS_q[1])
        syncIdles_q <= 4'h0;
      else if (symEdge && !descSync)
        syncIdles_q <= (rawWord == CG_IDLE) ? syncIdles_q + 4'h1 : 4'h0;
      linkOk_q <= linkOk_d;
    end
  end

  // ****************************************************************
  // Receive state machine
  // ****************************************************************
  fxr_state_t  state_q;
  logic [3:0]  idleRun_q;
  logic        pendNi_q, badStart, unstable_q;
  logic [4:0]  decoded;

  assign decoded  = dec5b(prevSym);
  // A J can span two words, so a stray word is judged one word later
  assign badStart = (state_q == S_IDLE) && pendNi_q && !anyHit;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q   <= S_IDLE;
      idleRun_q <= 4'h0;
      pendNi_q  <= 1'b0;
      phase_q   <= 3'h0;
    end
    else if (ce && !linkOk_q)
    begin
      state_q   <= S_IDLE;
      idleRun_q <= 4'h0;
      pendNi_q  <= 1'b0;
    end
    else if (symEdge)
    begin
      if (hist_q[4:0] == CG_IDLE)
        idleRun_q <= (idleRun_q == 4'hf) ? idleRun_q : idleRun_q + 4'h1;
      else
        idleRun_q <= 4'h0;
      case (state_q)
        S_IDLE:
        begin
          pendNi_q <= 1'b0;
          if (anyHit && (idleRun_q != 4'h0 || pendNi_q))
          begin
            phase_q <= hitPhase;
            state_q <= S_PRE_K;
          end
          else if (badStart)
            state_q <= S_BAD;
          else if (idleRun_q >= END_IDLES && hist_q[4:0] != CG_IDLE)
            pendNi_q <= 1'b1;
        end
        S_PRE_K:
          state_q <= S_DATA;
        S_DATA:
          if ((prevSym == CG_T && curSym == CG_R)
              || (prevSym == CG_IDLE && curSym == CG_IDLE))
            state_q <= S_IDLE;
        S_BAD:
          if (prevSym == CG_IDLE && curSym == CG_IDLE)
            state_q <= S_IDLE;
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // MII receive outputs
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      miiRx    <= '0;
      rxStrobe <= 1'b0;
    end
    else if (ce)
    begin
      rxStrobe <= symEdge;
      if (symEdge)
      begin
        miiRx <= '0;
        // Withheld while unstable; the monitor itself keeps running
        if (linkOk_q && !unstable_q)
          case (state_q)
            S_IDLE:
              if (anyHit && (idleRun_q != 4'h0 || pendNi_q))
                miiRx <= '{er: 1'b0, dv: 1'b1, crs: 1'b1, d: NIB_PREAMBLE};
              else if (badStart && !loopback_q[BIT_RX_BYPASS])
                miiRx <= '{er: 1'b1, dv: 1'b0, crs: 1'b1, d: NIB_BAD_START};
              else if (badStart)
                miiRx.crs <= 1'b1;
            S_PRE_K:
              miiRx <= '{er: 1'b0, dv: 1'b1, crs: 1'b1, d: NIB_PREAMBLE};
            S_DATA:
              if (!((prevSym == CG_T && curSym == CG_R)
                    || (prevSym == CG_IDLE && curSym == CG_IDLE)))
                miiRx <= '{er: decoded[4], dv: 1'b1, crs: 1'b1, d: decoded[3:0]};
            S_BAD:
              if (!(prevSym == CG_IDLE && curSym == CG_IDLE))
              begin
                miiRx.crs <= 1'b1;
                if (!loopback_q[BIT_RX_BYPASS])
                begin
                  miiRx.er <= 1'b1;
                  miiRx.d  <= NIB_BAD_START;
                end
              end
            default:
              miiRx <= '0;
          endcase
      end
    end
  end

  // ****************************************************************
  // Transmit gating
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      txEnOut <= 1'b0;
      txdOut  <= 4'h0;
      linkLed <= 1'b0;
    end
    else if (ce)
    begin
      txEnOut <= txEnIn && linkOk_q && !unstable_q;
      txdOut  <= (linkOk_q && !unstable_q) ? txdIn : 4'h0;
      linkLed <= linkOk_q && !anEnable;
    end
  end

  // ****************************************************************
  // Carrier stability monitor and counters
  // ****************************************************************
  logic [3:0]  badRun_q;
  logic [15:0] fcCnt_q, discCnt_q;
  logic        unstSticky_q, rdCfg, goodStart;

  assign goodStart = symEdge && (state_q == S_IDLE) && anyHit && linkOk_q
                     && (idleRun_q != 4'h0 || pendNi_q);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      badRun_q   <= 4'h0;
      unstable_q <= 1'b0;
      fcCnt_q    <= RST_COUNT;
      discCnt_q  <= RST_COUNT;
    end
    else if (ce)
    begin
      if (symEdge && badStart && linkOk_q)
      begin
        if (fcCnt_q != 16'hffff)
          fcCnt_q <= fcCnt_q + 16'h0001;
        if (badRun_q != CIM_BAD_LIMIT)
          badRun_q <= badRun_q + 4'h1;
      end
      else if (goodStart)
        badRun_q <= 4'h0;
      if (cimDis_q || goodStart)
        unstable_q <= 1'b0;
      else if (badRun_q == CIM_BAD_LIMIT && !unstable_q)
      begin
        unstable_q <= 1'b1;
        if (discCnt_q != 16'hffff)
          discCnt_q <= discCnt_q + 16'h0001;
      end
      if (cimDis_q)
        badRun_q <= 4'h0;
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  logic        access;
  logic [7:0]  idx;
  logic [15:0] rdVal;
  logic        known;

  assign access = psel && penable && pready;
  assign idx    = paddr[9:2];
  assign rdCfg  = access && !pwrite && idx == IDX_CODING_CFG_STATUS;

  always_comb
  begin
    rdVal = 16'h0000;
    known = 1'b1;
    case (idx)
      IDX_BASIC_LINK_STATUS: rdVal[BIT_LINK_VALID] = linkOk_q;
      IDX_DISCONNECT_COUNT:  rdVal = discCnt_q;
      IDX_FALSE_CARRIER:     rdVal = fcCnt_q;
      IDX_CODING_CFG_STATUS:
      begin
        rdVal[BIT_UNSTABLE]    = unstSticky_q;
        rdVal[BIT_CIM_DISABLE] = cimDis_q;
      end
      IDX_LOOPBACK_BYPASS:   rdVal = loopback_q;
      default:               known = 1'b0;
    endcase
    if (paddr[11:10] != 2'h0 || paddr[1:0] != 2'h0)
      known = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pready      <= 1'b0;
      prdata      <= 32'h00000000;
      pslverr     <= 1'b0;
      loopback_q  <= RST_LOOPBACK;
      cimDis_q    <= 1'b0;
      strapLoad_q <= 1'b1;
      unstSticky_q <= 1'b0;
    end
    else if (ce)
    begin
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite && known) ? {16'h0000, rdVal} : 32'h00000000;
      pslverr <= psel && !penable && !known;
      strapLoad_q <= 1'b0;
      if (strapLoad_q)
        cimDis_q <= strapS_q[1];
      else if (access && pwrite && known && idx == IDX_CODING_CFG_STATUS)
        cimDis_q <= pwdata[BIT_CIM_DISABLE];
      if (access && pwrite && known && idx == IDX_LOOPBACK_BYPASS)
        loopback_q <= pwdata[15:0];
      // New event wins over a clearing read
      if (unstable_q)
        unstSticky_q <= 1'b1;
      else if (rdCfg)
        unstSticky_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_badSym;
    symEdge && state_q == S_BAD && linkOk_q && !unstable_q
      && !loopback_q[BIT_RX_BYPASS] && !(prevSym == CG_IDLE && curSym == CG_IDLE);
  endsequence

  property p_bad_out;
    @(posedge clk) disable iff (rst) s_badSym |=> miiRx.er && miiRx.d == NIB_BAD_START;
  endproperty
  a_bad_out: assert property (p_bad_out) else $error("bad start output wrong");

  property p_fc_inc;
    @(posedge clk) disable iff (rst) symEdge && badStart && linkOk_q
      |=> fcCnt_q == $past(fcCnt_q) + 16'h0001 || fcCnt_q == 16'hffff;
  endproperty
  a_fc_inc: assert property (p_fc_inc) else $error("false carrier count off");

  property p_pre;
    @(posedge clk) disable iff (rst) goodStart && !unstable_q
      |=> miiRx.dv && miiRx.d == NIB_PREAMBLE && state_q == S_PRE_K;
  endproperty
  a_pre: assert property (p_pre) else $error("preamble not emitted");

  property p_link_hold;
    @(posedge clk) disable iff (rst) $rose(linkOk_q) |-> $past(sdS_q[1], 2);
  endproperty
  a_link_hold: assert property (p_link_hold) else $error("link without detect");

  property p_an;
    @(posedge clk) disable iff (rst) linkOk_q && $past(anEnable) && anEnable
      |-> $past(descSync) && $past(anSel100);
  endproperty
  a_an: assert property (p_an) else $error("link without negotiation");

  property p_block;
    @(posedge clk) disable iff (rst) ce && !linkOk_q |=> state_q == S_IDLE && !txEnOut;
  endproperty
  a_block: assert property (p_block) else $error("path not blocked");

  property p_sticky;
    @(posedge clk) disable iff (rst) $rose(unstable_q) |=> unstSticky_q [*2];
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky bit lost");

  property p_disc;
    @(posedge clk) disable iff (rst) $rose(unstable_q)
      |-> discCnt_q == $past(discCnt_q) + 16'h0001 || discCnt_q == 16'hffff;
  endproperty
  a_disc: assert property (p_disc) else $error("disconnect count off");

  property p_withhold;
    @(posedge clk) disable iff (rst) symEdge && unstable_q |=> !miiRx.dv && !miiRx.crs;
  endproperty
  a_withhold: assert property (p_withhold) else $error("data passed while unstable");
endmodule
`default_nettype wire

// ==== tb/fxrpcs_line_model.sv ====
// Link-side model that feeds unaligned 5-bit words to the receive back end
`timescale 1ns/100ps
`default_nettype none
module fxrpcs_line_model (
  output logic       symClk,
  output logic [4:0] descWord,
  output logic [4:0] nrzWord,
  input  wire logic  useNrz
);
  logic       bitQ[$];
  logic [4:0] w;
  logic       busy;
  // Recovered clock runs free: idles fill the line between frames
  initial
  begin
    symClk = 1'b0;
    descWord = 5'h1f;
    nrzWord = 5'h1f;
    forever #40 symClk = ~symClk;
  end
  // Unselected path carries the inverse during frames, so a wrong select shows
  always @(posedge symClk)
  begin
    busy = bitQ.size() > 0;
    for (int i = 4; i >= 0; i--)
      w[i] = (bitQ.size() > 0) ? bitQ.pop_front() : 1'b1;
    descWord <= (useNrz && busy) ? ~w : w;
    nrzWord <= (!useNrz && busy) ? ~w : w;
  end
  task automatic send(input logic [4:0] cg);
    for (int i = 4; i >= 0; i--)
      bitQ.push_back(cg[i]);
  endtask
  task automatic ones(input int n);
    repeat (n) bitQ.push_back(1'b1);
  endtask
endmodule
`default_nettype wire

// ==== tb/fxrpcs_rx_tb.sv ====
// Self-checking bench for the receive coding back end
`timescale 1ns/100ps
`default_nettype none
module fxrpcs_rx_tb
  import fxrpcs_pkg::*;
();
  localparam logic [4:0] CODE [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e,
    5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        symClk;
  logic [4:0]  descWord;
  logic [4:0]  nrzWord;
  logic        signalDetect;
  logic        repeaterStrap;
  logic        anEnable;
  logic        anSel100;
  logic        txEnIn;
  logic [3:0]  txdIn;
  fxr_mii_rx_t miiRx;
  logic        rxStrobe;
  logic        txEnOut;
  logic [3:0]  txdOut;
  logic        linkLed;
  logic        useNrz;
  logic [31:0] rdData;
  logic        rdErr;
  logic [3:0]  rxQ[$];
  int          erCnt;
  int          e0;
  int          w;
  int          failCount;
  int          samplesChecked;

  fxrpcs_rx #(.SD_HOLD_CYCLES(20)) fxrpcs_rx_inst (
    .clk(clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .symClk(symClk), .descWord(descWord),
    .nrzWord(nrzWord), .signalDetect(signalDetect), .repeaterStrap(repeaterStrap),
    .anEnable(anEnable), .anSel100(anSel100), .txEnIn(txEnIn), .txdIn(txdIn),
    .miiRx(miiRx), .rxStrobe(rxStrobe), .txEnOut(txEnOut), .txdOut(txdOut),
    .linkLed(linkLed)
  );
  fxrpcs_line_model fxrpcs_line_model_inst (
    .symClk(symClk), .descWord(descWord), .nrzWord(nrzWord), .useNrz(useNrz)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic finishTest();
    $display("Checks %0d, mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp)
    begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      failCount++;
      finishTest();
    end
  endtask
  task automatic rdchk(input string nm, input logic [7:0] idx, input logic [31:0] m,
                       input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(nm, exp, rdData & m);
  endtask
  // Pipeline flush: queue drained, then a dozen idle symbols
  task automatic drain();
    for (w = 0; w < 3000 && fxrpcs_line_model_inst.bitQ.size() > 0; w++)
      @(posedge clk);
    if (w >= 3000)
    begin
      failCount++;
      finishTest();
    end
    repeat (12) @(posedge symClk);
  endtask
  task automatic frame(input bit tr, input bit check);
    rxQ.delete();
    fxrpcs_line_model_inst.ones(3);
    fxrpcs_line_model_inst.send(CG_JK[9:5]);
    fxrpcs_line_model_inst.send(CG_JK[4:0]);
    for (int i = 0; i < 16; i++)
      fxrpcs_line_model_inst.send(CODE[i]);
    if (tr)
    begin
      fxrpcs_line_model_inst.send(CG_T);
      fxrpcs_line_model_inst.send(CG_R);
    end
    drain();
    if (check)
    begin
      if (tr)
        chk("nibbleCount", 18, rxQ.size());
      for (int i = 0; i < 18; i++)
        chk("nibble", (i < 2) ? NIB_PREAMBLE : 4'(i - 2), rxQ[i]);
      chk("dvEnd", 0, miiRx.dv);
    end
  endtask
  // Non-idle after idles with no start pair
  task automatic badStart();
    fxrpcs_line_model_inst.ones(2);
    repeat (3) fxrpcs_line_model_inst.send(CODE[0]);
    drain();
  endtask

  always @(posedge clk)
    if (rxStrobe === 1'b1)
    begin
      if (miiRx.dv === 1'b1)
        rxQ.push_back(miiRx.d);
      if (miiRx.er === 1'b1)
      begin
        erCnt++;
        chk("badNibble", NIB_BAD_START, miiRx.d);
      end
    end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    {rst, repeaterStrap, anSel100, txEnIn} = 4'hf;
    {psel, penable, pwrite, signalDetect, anEnable, useNrz} = 6'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    txdIn = 4'ha;
    {erCnt, failCount, samplesChecked} = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdchk("linkBit", IDX_BASIC_LINK_STATUS, 32'h4, 32'h0);
    rdchk("discCount", IDX_DISCONNECT_COUNT, '1, 32'h0);
    rdchk("fcCount", IDX_FALSE_CARRIER, '1, 32'h0);
    rdchk("cimDisable", IDX_CODING_CFG_STATUS, 32'h30, 32'h20);
    rdchk("loopback", IDX_LOOPBACK_BYPASS, '1, 32'h0);
    apb(1'b0, 8'h02, 32'h0);
    chk("unmappedErr", 1, rdErr);
    apb(1'b1, IDX_CODING_CFG_STATUS, 32'h0);
    rdchk("cimDisable", IDX_CODING_CFG_STATUS, 32'h20, 32'h0);
    chk("txGated", 0, txEnOut);
    signalDetect <= 1'b1;
    repeat (10) @(posedge clk);
    chk("earlyLink", 0, linkLed);
    for (w = 0; w < 200 && linkLed !== 1'b1; w++)
      @(posedge clk);
    chk("linkLed", 1, linkLed);
    if (w >= 200)
      finishTest();
    rdchk("linkBit", IDX_BASIC_LINK_STATUS, 32'h4, 32'h4);
    chk("txPass", 5'h1a, {txEnOut, txdOut});
    frame(1'b1, 1'b1);
    apb(1'b1, IDX_LOOPBACK_BYPASS, 32'h800);
    e0 = erCnt;
    badStart();
    chk("bypassNoEr", e0, erCnt);
    apb(1'b1, IDX_LOOPBACK_BYPASS, 32'h0);
    frame(1'b1, 1'b1);
    badStart();
    chk("erShown", 1, erCnt > e0);
    chk("crsEnd", 0, miiRx.crs);
    rdchk("fcCount", IDX_FALSE_CARRIER, '1, 32'h2);
    badStart();
    rdchk("discCount", IDX_DISCONNECT_COUNT, '1, 32'h1);
    e0 = erCnt;
    badStart();
    chk("withheld", e0, erCnt);
    chk("txDropped", 0, txEnOut);
    rdchk("discCount", IDX_DISCONNECT_COUNT, '1, 32'h1);
    rdchk("fcCount", IDX_FALSE_CARRIER, '1, 32'h4);
    rdchk("sticky", IDX_CODING_CFG_STATUS, 32'h10, 32'h10);
    rdchk("sticky", IDX_CODING_CFG_STATUS, 32'h10, 32'h10);
    frame(1'b1, 1'b0);
    chk("txBack", 1, txEnOut);
    rdchk("sticky", IDX_CODING_CFG_STATUS, 32'h10, 32'h10);
    rdchk("sticky", IDX_CODING_CFG_STATUS, 32'h10, 32'h0);
    useNrz <= 1'b1;
    apb(1'b1, IDX_LOOPBACK_BYPASS, 32'h1000);
    frame(1'b0, 1'b1);
    // Give the descrambler sync its dozen idles before negotiation counts
    repeat (16) @(posedge symClk);
    @(posedge clk);
    anEnable <= 1'b1;
    repeat (4) @(posedge clk);
    chk("ledNegotiating", 0, linkLed);
    rdchk("linkBit", IDX_BASIC_LINK_STATUS, 32'h4, 32'h4);
    anSel100 <= 1'b0;
    repeat (4) @(posedge clk);
    rdchk("linkBit", IDX_BASIC_LINK_STATUS, 32'h4, 32'h0);
    finishTest();
  end
endmodule
`default_nettype wire
